//--- logic/mid_core.sv
`timescale 1ns/1ns
// Overview of operation
// - Instructions are one 16-bit word, except one kind that spans two consecutive words.
// - A byte operation with destination bit 0 writes the working register, 1 the file.
// - The second word of a double-word instruction carries all ones in its top nibble.
// - A second word reached on its own executes as a no-operation.
// - Single-word instructions take one cycle, two when they change the PC, the extra idle.
// - A double-word instruction takes two instruction cycles.
// - One instruction cycle is made of four consecutive clock periods.
// - A file instruction reads its register first, modifies it, then stores the result.
// - An 8-bit file address field selects one of 256 file registers within a bank.
// - The bit-set instruction forces the selected bit of the file register to one.
// - Bank bit 0 addresses the access bank, bank bit 1 the bank select register's bank.
// - The relative branch loads PC+2+2n, touches no flag and idles its second cycle.
// - The negate instruction stores the two's complement and updates N, OV, C, DC and Z.
module mid_core (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  output logic [15:0]      prog_addr_out,
  input  wire logic [15:0] prog_word_in,
  output logic [11:0]      data_addr_out,
  output logic             data_rd_out,
  input  wire logic [7:0]  data_rdata_in,
  output logic             data_wr_out,
  output logic [7:0]       data_wdata_out,
  input  wire logic        bank_load_in,
  input  wire logic [3:0]  bank_value_in,
  output logic [3:0]       bank_select_out,
  output logic [7:0]       working_register_out,
  output logic [4:0]       status_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // State
  // ****************************************
  mid_pkg::mid_phase_t phase;
  mid_pkg::mid_op_t    exec_op_q;
  logic [15:0]         pc_q;
  logic [15:0]         instr_q;
  logic                second_q;
  logic [7:0]          hold_q;
  logic [7:0]          opnd_q;
  logic [11:0]         addr_q;
  logic                rd_q;
  logic                wr_q;
  logic [7:0]          wdata_q;
  logic                to_work_q;
  logic [4:0]          flags_q;
  logic [4:0]          flag_en_q;
  logic [7:0]          work_q;
  logic [4:0]          status_q;
  logic [3:0]          bank_q;
  logic [15:0]         rel_off;
  logic [15:0]         rel_tgt;
  logic                file_op;

  mid_alu_if alu_bus ();

  // ****************************************
  // Decoding
  // ****************************************
  function automatic mid_pkg::mid_op_t decode_op(input logic [15:0] w, input logic sec);
    mid_pkg::mid_op_t op;
    op = mid_pkg::OP_NOP;
    if (sec) begin
      if (w[mid_pkg::OPC_HI -: $bits(mid_pkg::SECOND_PREFIX)] == mid_pkg::SECOND_PREFIX) begin
        op = mid_pkg::OP_DW2;
      end
    end else if (w == mid_pkg::NOP_WORD) begin
      op = mid_pkg::OP_NOP;
    end else if (w[mid_pkg::OPC_HI -: $bits(mid_pkg::REL_PREFIX)] == mid_pkg::REL_PREFIX) begin
      op = mid_pkg::OP_REL;
    end else if (w[mid_pkg::OPC_HI -: $bits(mid_pkg::SET_PREFIX)] == mid_pkg::SET_PREFIX) begin
      op = mid_pkg::OP_SET;
    end else if (w[mid_pkg::OPC_HI -: $bits(mid_pkg::NEG_PREFIX)] == mid_pkg::NEG_PREFIX) begin
      op = mid_pkg::OP_NEG;
    end else if (w[mid_pkg::OPC_HI -: $bits(mid_pkg::MOVE_PREFIX)] == mid_pkg::MOVE_PREFIX) begin
      op = mid_pkg::OP_MOVE;
    end else if (w[mid_pkg::OPC_HI -: $bits(mid_pkg::DW_PREFIX)] == mid_pkg::DW_PREFIX) begin
      op = mid_pkg::OP_DW1;
    end
    // lone second word and unknown words fall through as idle
    return op;
  endfunction

  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic sec,
                                            input logic [3:0] bank);
    logic [11:0] a;
    a = w[mid_pkg::LADDR_HI:0];
    if (!sec && (w[mid_pkg::OPC_HI -: $bits(mid_pkg::DW_PREFIX)] != mid_pkg::DW_PREFIX)) begin
      a = w[mid_pkg::A_BIT] ? {bank, w[mid_pkg::F_HI:0]}
                            : {mid_pkg::ACCESS_BANK, w[mid_pkg::F_HI:0]};
    end
    return a;
  endfunction

  assign file_op = (exec_op_q == mid_pkg::OP_SET) || (exec_op_q == mid_pkg::OP_NEG) ||
                   (exec_op_q == mid_pkg::OP_MOVE) || (exec_op_q == mid_pkg::OP_DW1) ||
                   (exec_op_q == mid_pkg::OP_DW2);

  // ****************************************
  // Phase sequencing
  // ****************************************
  // four clocks per cycle
  mid_phase_gen u_phase (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .phase_out (phase)
  );

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      exec_op_q <= mid_pkg::OP_NOP;
      addr_q    <= 12'h000;
    end else if (phase == mid_pkg::PH_Q1) begin
      exec_op_q <= decode_op(instr_q, second_q);
      addr_q    <= file_addr(instr_q, second_q, bank_q);
    end
  end

  // ****************************************
  // Fetch and program counter
  // ****************************************
  // Offset is n words, so 2n in bytes
  assign rel_off = {{(mid_pkg::PC_W - mid_pkg::REL_OFF_HI - 2){instr_q[mid_pkg::REL_OFF_HI]}},
                    instr_q[mid_pkg::REL_OFF_HI:0], 1'b0};
  // PC already points past this word, hence PC+2+2n
  assign rel_tgt = pc_q + rel_off;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_q    <= 16'h0000;
      instr_q <= mid_pkg::NOP_WORD;
    end else if (phase == mid_pkg::PH_Q4) begin
      if (exec_op_q == mid_pkg::OP_REL) begin
        pc_q    <= rel_tgt;
        // prefetched word dropped, idle cycle follows
        instr_q <= mid_pkg::NOP_WORD;
      end else begin
        pc_q    <= pc_q + mid_pkg::PC_STEP;
        instr_q <= prog_word_in;
      end
    end
  end

  // second word consumed in the next cycle
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      second_q <= 1'b0;
      hold_q   <= 8'h00;
    end else if (phase == mid_pkg::PH_Q4) begin
      second_q <= (exec_op_q == mid_pkg::OP_DW1);
      if (exec_op_q == mid_pkg::OP_DW1) begin
        hold_q <= opnd_q;
      end
    end
  end

  // ****************************************
  // Data port
  // ****************************************
  assign alu_bus.op     = exec_op_q;
  assign alu_bus.opnd   = (exec_op_q == mid_pkg::OP_DW2) ? hold_q : opnd_q;
  assign alu_bus.bitsel = instr_q[mid_pkg::BIT_HI:mid_pkg::BIT_LO];

  mid_alu u_alu (
    .alu (alu_bus.alu)
  );

  // every file instruction reads first, even the second word that only writes
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= 1'b0;
      opnd_q <= 8'h00;
    end else begin
      rd_q <= (phase == mid_pkg::PH_Q1) && (decode_op(instr_q, second_q) != mid_pkg::OP_NOP) &&
              (decode_op(instr_q, second_q) != mid_pkg::OP_REL);
      if (phase == mid_pkg::PH_Q2) begin
        opnd_q <= data_rdata_in;
      end
    end
  end

  // process in third phase, write in fourth
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_q      <= 1'b0;
      wdata_q   <= 8'h00;
      to_work_q <= 1'b0;
      flags_q   <= 5'h00;
      flag_en_q <= 5'h00;
    end else if (phase == mid_pkg::PH_Q3) begin
      wdata_q   <= alu_bus.result;
      flags_q   <= alu_bus.flags;
      flag_en_q <= alu_bus.flag_en;
      to_work_q <= (exec_op_q == mid_pkg::OP_MOVE) && !instr_q[mid_pkg::D_BIT];
      wr_q      <= (exec_op_q == mid_pkg::OP_SET) || (exec_op_q == mid_pkg::OP_NEG) ||
                   (exec_op_q == mid_pkg::OP_DW2) ||
                   ((exec_op_q == mid_pkg::OP_MOVE) && instr_q[mid_pkg::D_BIT]);
    end else begin
      wr_q <= 1'b0;
    end
  end

  // ****************************************
  // Working register, status, bank select
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= 8'h00;
    end else if ((phase == mid_pkg::PH_Q4) && to_work_q) begin
      work_q <= wdata_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 5'h00;
    end else if (phase == mid_pkg::PH_Q4) begin
      status_q <= (status_q & ~flag_en_q) | (flags_q & flag_en_q);
    end
  end

  // Loaded from outside; a load mid-cycle affects only the next decode
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= 4'h0;
    end else if (bank_load_in) begin
      bank_q <= bank_value_in;
    end
  end

  assign prog_addr_out        = pc_q;
  assign data_addr_out        = addr_q;
  assign data_rd_out          = rd_q;
  assign data_wr_out          = wr_q;
  assign data_wdata_out       = wdata_q;
  assign bank_select_out      = bank_q;
  assign working_register_out = work_q;
  assign status_out           = status_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  chk_phase_rotation: assert property (
    (phase == mid_pkg::PH_Q2) |=> (phase == mid_pkg::PH_Q3) ##1 (phase == mid_pkg::PH_Q4)
      ##1 (phase == mid_pkg::PH_Q1) ##1 (phase == mid_pkg::PH_Q2))
    else $error("phase rotation broken");

  chk_read_then_write: assert property (
    data_wr_out |-> $past(data_rd_out, 2) && (data_addr_out == $past(data_addr_out, 2)))
    else $error("file write without prior read");

  chk_read_phase: assert property (
    data_rd_out |-> file_op && (phase == mid_pkg::PH_Q2))
    else $error("read strobe outside the read phase of a file instruction");

  chk_neg_result: assert property (
    (phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_NEG)
      |-> data_wr_out && (data_wdata_out == 8'(~opnd_q + 8'h01)))
    else $error("negate result wrong");

  chk_neg_flags: assert property (
    (phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_NEG)
      |=> (status_q[mid_pkg::ST_Z] == ($past(opnd_q) == mid_pkg::ZERO_BYTE)) &&
          (status_q[mid_pkg::ST_OV] == ($past(opnd_q) == mid_pkg::OV_VALUE)) &&
          (status_q[mid_pkg::ST_C] == ($past(opnd_q) == mid_pkg::ZERO_BYTE)))
    else $error("negate flags wrong");

  chk_set_bit: assert property (
    (phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_SET)
      |-> data_wr_out &&
          (data_wdata_out == (opnd_q | (mid_pkg::BIT_ONE <<
                                        instr_q[mid_pkg::BIT_HI:mid_pkg::BIT_LO]))))
    else $error("bit set result wrong");

  chk_dest_work: assert property (
    (phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_MOVE) && !instr_q[mid_pkg::D_BIT]
      |-> !data_wr_out ##1 (work_q == $past(data_wdata_out)))
    else $error("destination bit ignored");

  chk_access_bank: assert property (
    (phase == mid_pkg::PH_Q2) && !instr_q[mid_pkg::A_BIT] &&
      ((exec_op_q == mid_pkg::OP_SET) || (exec_op_q == mid_pkg::OP_NEG))
      |-> (data_addr_out[mid_pkg::LADDR_HI -: mid_pkg::BANK_W] == mid_pkg::ACCESS_BANK))
    else $error("access bank not used");

  chk_rel_target: assert property (
    (phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_REL)
      |=> (pc_q == $past(rel_tgt)) && $stable(status_q) ##1 (exec_op_q == mid_pkg::OP_NOP))
    else $error("branch target or idle cycle wrong");

  chk_dw_second: assert property (
    (phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_DW1)
      |=> second_q ##1 ((exec_op_q == mid_pkg::OP_DW2) || (exec_op_q == mid_pkg::OP_NOP)))
    else $error("double word not in two cycles");

  chk_second_alone: assert property (
    (phase == mid_pkg::PH_Q2) && !second_q &&
      (instr_q[mid_pkg::OPC_HI -: $bits(mid_pkg::SECOND_PREFIX)] == mid_pkg::SECOND_PREFIX)
      |-> (exec_op_q == mid_pkg::OP_NOP))
    else $error("lone second word not idle");

  chk_nop_quiet: assert property (
    (phase == mid_pkg::PH_Q2) && (exec_op_q == mid_pkg::OP_NOP)
      |-> (!data_wr_out && !data_rd_out && $stable(work_q))[*3])
    else $error("idle cycle touched state");

  cov_branch: cover property ((phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_REL));
  cov_negate: cover property ((phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_NEG));
  cov_double: cover property ((phase == mid_pkg::PH_Q4) && (exec_op_q == mid_pkg::OP_DW2));
  cov_to_work: cover property ((phase == mid_pkg::PH_Q4) && to_work_q);

endmodule

//--- include/mid_pkg.sv
package mid_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned PC_W    = 16;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned FLAG_W  = 5;

  // ****************************************
  // Phases and operations
  // ****************************************
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } mid_phase_t;

  typedef enum logic [6:0] {
    OP_NOP  = 7'b0000001,
    OP_REL  = 7'b0000010,
    OP_SET  = 7'b0000100,
    OP_NEG  = 7'b0001000,
    OP_MOVE = 7'b0010000,
    OP_DW1  = 7'b0100000,
    OP_DW2  = 7'b1000000
  } mid_op_t;

  // ****************************************
  // Encodings and field positions
  // ****************************************
  localparam logic [15:0] NOP_WORD      = 16'h0000;
  localparam logic [4:0]  REL_PREFIX    = 5'h1a;
  localparam logic [3:0]  SET_PREFIX    = 4'h8;
  localparam logic [6:0]  NEG_PREFIX    = 7'h36;
  localparam logic [5:0]  MOVE_PREFIX   = 6'h14;
  localparam logic [3:0]  DW_PREFIX     = 4'hc;
  localparam logic [3:0]  SECOND_PREFIX = 4'hf;
  localparam logic [3:0]  ACCESS_BANK   = 4'h0;
  localparam logic [15:0] PC_STEP       = 16'h0002;
  localparam logic [7:0]  BIT_ONE       = 8'h01;
  localparam logic [7:0]  OV_VALUE      = 8'h80;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  localparam int OPC_HI     = 15;
  localparam int REL_OFF_HI = 10;
  localparam int BIT_HI     = 11;
  localparam int BIT_LO     = 9;
  localparam int D_BIT      = 9;
  localparam int A_BIT      = 8;
  localparam int F_HI       = 7;
  localparam int LADDR_HI   = 11;

  // ****************************************
  // Status flag positions
  // ****************************************
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam int ST_N  = 4;

endpackage

//--- include/mid_alu_if.sv
`timescale 1ns/1ns
interface mid_alu_if;
  mid_pkg::mid_op_t op;
  logic [7:0]       opnd;
  logic [2:0]       bitsel;
  logic [7:0]       result;
  logic [4:0]       flags;
  logic [4:0]       flag_en;
  modport core (output op, opnd, bitsel, input result, flags, flag_en);
  modport alu  (input op, opnd, bitsel, output result, flags, flag_en);
endinterface

//--- logic/mid_phase_gen.sv
`timescale 1ns/1ns
module mid_phase_gen (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  output mid_pkg::mid_phase_t phase_out
);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_out <= mid_pkg::PH_Q1;
    end else begin
      case (phase_out)
        mid_pkg::PH_Q1: phase_out <= mid_pkg::PH_Q2;
        mid_pkg::PH_Q2: phase_out <= mid_pkg::PH_Q3;
        mid_pkg::PH_Q3: phase_out <= mid_pkg::PH_Q4;
        mid_pkg::PH_Q4: phase_out <= mid_pkg::PH_Q1;
        default:        phase_out <= mid_pkg::PH_Q1;
      endcase
    end
  end

endmodule

//--- logic/mid_alu.sv
`timescale 1ns/1ns
module mid_alu (
  mid_alu_if.alu alu
);

  logic [8:0] neg_sum;
  logic [4:0] neg_low;

  always_comb begin
    neg_sum     = {1'b0, ~alu.opnd} + 9'h001;
    neg_low     = {1'b0, ~alu.opnd[3:0]} + 5'h01;
    alu.result  = alu.opnd;
    alu.flags   = '0;
    alu.flag_en = '0;
    case (alu.op)
      mid_pkg::OP_NEG: begin
        alu.result               = neg_sum[7:0];
        alu.flags[mid_pkg::ST_C]  = neg_sum[8];
        alu.flags[mid_pkg::ST_DC] = neg_low[4];
        alu.flags[mid_pkg::ST_Z]  = (neg_sum[7:0] == mid_pkg::ZERO_BYTE);
        alu.flags[mid_pkg::ST_N]  = neg_sum[7];
        // Only the most negative value overflows
        alu.flags[mid_pkg::ST_OV] = (alu.opnd == mid_pkg::OV_VALUE);
        alu.flag_en              = '1;
      end
      mid_pkg::OP_SET: begin
        alu.result = alu.opnd | (mid_pkg::BIT_ONE << alu.bitsel);
      end
      mid_pkg::OP_MOVE: begin
        alu.flags[mid_pkg::ST_Z]   = (alu.opnd == mid_pkg::ZERO_BYTE);
        alu.flags[mid_pkg::ST_N]   = alu.opnd[7];
        alu.flag_en[mid_pkg::ST_Z] = 1'b1;
        alu.flag_en[mid_pkg::ST_N] = 1'b1;
      end
      default: begin
        alu.result = alu.opnd;
      end
    endcase
  end

endmodule

//--- verif/mid_mem_model.sv
`timescale 1ns/1ns
module mid_mem_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] prog_addr_in,
  output logic [15:0]      prog_word_out,
  input  wire logic [11:0] data_addr_in,
  input  wire logic        data_rd_in,
  output logic [7:0]       data_rdata_out,
  input  wire logic        data_wr_in,
  input  wire logic [7:0]  data_wdata_in
);
  logic [15:0] prog [0:63];
  logic [7:0]  ram  [0:4095];
  logic [7:0]  last_q = 8'h5a;

  // ****************************************
  // Program side
  // ****************************************
  // whole words only
  // Words past the end read as no-operation
  assign prog_word_out = (prog_addr_in[15:7] == 9'h000) ? prog[prog_addr_in[6:1]] : 16'h0000;

  // ****************************************
  // File register side
  // ****************************************
  // Unselected bus shows the inverse of the last value, never a stale copy
  assign data_rdata_out = data_rd_in ? ram[data_addr_in] : ~last_q;

  always @(posedge mclk_in) begin
    if (data_rd_in) begin
      last_q <= ram[data_addr_in];
    end
    if (data_wr_in) begin
      ram[data_addr_in] <= data_wdata_in;
    end
  end
endmodule

//--- verif/mcu_instruction_decode_exec_bench.sv
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end

module mcu_instruction_decode_exec_bench;
  logic        mclk_in;
  logic        rst_n_in;
  logic [15:0] prog_addr;
  logic [15:0] prog_word;
  logic [11:0] data_addr;
  logic        data_rd;
  logic [7:0]  data_rdata;
  logic        data_wr;
  logic [7:0]  data_wdata;
  logic        bank_load;
  logic [3:0]  bank_value;
  logic [3:0]  bank_sel;
  logic [7:0]  work_reg;
  logic [4:0]  status;
  int          n_mismatch;
  int          total_checks;
  int          cyc;
  int          rd_t[$];
  int          wr_t[$];

  mid_core dut (
    .mclk_in              (mclk_in),
    .rst_n_in             (rst_n_in),
    .prog_addr_out        (prog_addr),
    .prog_word_in         (prog_word),
    .data_addr_out        (data_addr),
    .data_rd_out          (data_rd),
    .data_rdata_in        (data_rdata),
    .data_wr_out          (data_wr),
    .data_wdata_out       (data_wdata),
    .bank_load_in         (bank_load),
    .bank_value_in        (bank_value),
    .bank_select_out      (bank_sel),
    .working_register_out (work_reg),
    .status_out           (status)
  );

  mid_mem_model mem (
    .mclk_in        (mclk_in),
    .prog_addr_in   (prog_addr),
    .prog_word_out  (prog_word),
    .data_addr_in   (data_addr),
    .data_rd_in     (data_rd),
    .data_rdata_out (data_rdata),
    .data_wr_in     (data_wr),
    .data_wdata_in  (data_wdata)
  );

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  // ****************************************
  // Strobe log and hang guard
  // ****************************************
  always @(posedge mclk_in) begin
    cyc++;
    if (data_rd === 1'b1) rd_t.push_back(cyc);
    if (data_wr === 1'b1) wr_t.push_back(cyc);
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Reset held while memories are rewritten, so no stray strobe lands
  task automatic clear;
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    for (int i = 0; i < 64; i++) mem.prog[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) mem.ram[i] = 8'h00;
  endtask

  task automatic start(input int ncyc);
    repeat (2) @(negedge mclk_in);
    rd_t.delete();
    wr_t.delete();
    rst_n_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    bank_load = 1'b1;
    @(negedge mclk_in);
    bank_load = 1'b0;
    repeat (4 * ncyc + 8) @(negedge mclk_in);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_negate;
    clear();
    mem.ram[12'h011] = 8'h3a;
    mem.ram[12'h012] = 8'h80;
    mem.prog[1] = 16'h6c10;
    mem.prog[2] = 16'h6c11;
    mem.prog[3] = 16'h6c12;
    start(6);
    `CHK("neg zero", 8'h00, mem.ram[12'h010])
    `CHK("neg 3a", 8'hc6, mem.ram[12'h011])
    `CHK("neg 80", 8'h80, mem.ram[12'h012])
    `CHK("neg flags", 5'b11010, status)
    `CHK("neg reads", 3, rd_t.size())
    `CHK("cycle length", 4, rd_t[1] - rd_t[0])
    `CHK("read to write", 2, wr_t[0] - rd_t[0])
  endtask

  task automatic t_bit_set;
    clear();
    bank_value = 4'h3;
    mem.ram[12'h020] = 8'h0a;
    mem.prog[1] = 16'h8e20;
    mem.prog[2] = 16'h8120;
    mem.prog[3] = 16'h8cff;
    start(6);
    `CHK("bank value", 4'h3, bank_sel)
    `CHK("bit 7 access", 8'h8a, mem.ram[12'h020])
    `CHK("bit 0 banked", 8'h01, mem.ram[12'h320])
    `CHK("top file addr", 8'h40, mem.ram[12'h0ff])
    `CHK("set flags", 5'b00000, status)
    bank_value = 4'h0;
  endtask

  task automatic t_move;
    clear();
    mem.ram[12'h030] = 8'h55;
    mem.prog[1] = 16'h5030;
    mem.prog[2] = 16'h5231;
    start(6);
    `CHK("work dest", 8'h55, work_reg)
    `CHK("file kept", 8'h55, mem.ram[12'h030])
    `CHK("one write", 1, wr_t.size())
    `CHK("two reads", 2, rd_t.size())
    `CHK("flags after nop", 5'b00100, status)
  endtask

  task automatic t_branch;
    clear();
    mem.prog[1] = 16'h6c40;
    mem.prog[2] = 16'hd002;
    mem.prog[3] = 16'h8e41;
    mem.prog[4] = 16'h8e42;
    mem.prog[5] = 16'h8e43;
    mem.prog[6] = 16'hd7ff;
    start(12);
    `CHK("skipped 1", 8'h00, mem.ram[12'h041])
    `CHK("skipped 2", 8'h00, mem.ram[12'h042])
    `CHK("target run", 8'h80, mem.ram[12'h043])
    `CHK("branch flags", 5'b00111, status)
    `CHK("reads", 2, rd_t.size())
    `CHK("branch cost", 12, rd_t[1] - rd_t[0])
    `CHK("self loop pc", 1'b1, (prog_addr == 16'h000c) || (prog_addr == 16'h000e))
  endtask

  task automatic t_dword;
    clear();
    mem.ram[12'h050] = 8'h77;
    mem.ram[12'h051] = 8'h01;
    mem.prog[1] = 16'hc050;
    mem.prog[2] = 16'hf060;
    mem.prog[3] = 16'hf070;
    mem.prog[4] = 16'h6c51;
    start(8);
    `CHK("copy dest", 8'h77, mem.ram[12'h060])
    `CHK("lone second", 8'h00, mem.ram[12'h070])
    `CHK("after copy", 8'hff, mem.ram[12'h051])
    `CHK("reads", 3, rd_t.size())
    `CHK("writes", 2, wr_t.size())
    `CHK("dword spacing", 4, rd_t[1] - rd_t[0])
    `CHK("lone nop cycle", 8, rd_t[2] - rd_t[1])
  endtask

  initial begin
    rst_n_in   = 1'b0;
    bank_load  = 1'b0;
    bank_value = 4'h0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(negedge mclk_in);
    t_negate();
    t_bit_set();
    t_move();
    t_branch();
    t_dword();
    print_verdict();
  end
endmodule
